// ==== inc/irq_route_pkg.sv ====
// Purpose: Shared constants and types for the peripheral interrupt routing block
// Assumes: One 125 MHz system clock, AXI4-Lite register access
// Notes:   All reset values are zero; unused lines are masked except in event enable and priority
package irq_route_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NUM_LINES = 32;  // Controller lines
   localparam int NUM_PRIO_BITS = 2;  // Four priority levels
   localparam int NUM_FLAGS = 8;  // Flags per peripheral
   localparam int ADDR_W = 12;

   // ------------------------------------------------------------------
   // Line assignment (bit set = line driven by a peripheral)
   // ------------------------------------------------------------------
   localparam logic [4:0] LINE_POWER_MANAGER = 5'h00;
   localparam logic [4:0] LINE_SYSTEM_CONTROL = 5'h01;
   localparam logic [4:0] LINE_WATCHDOG = 5'h02;
   localparam logic [4:0] LINE_RT_COUNTER = 5'h03;
   localparam logic [4:0] LINE_EXT_IRQ_CTRL = 5'h04;
   localparam logic [4:0] LINE_NVM_CTRL = 5'h05;
   localparam logic [4:0] LINE_DMA_CTRL = 5'h06;
   localparam logic [4:0] LINE_EVENT_SYSTEM = 5'h08;
   localparam logic [4:0] LINE_SERIAL_FIRST = 5'h09;  // Instances 0..5 -> 9..14
   localparam logic [4:0] LINE_CTRL_TIMER_FIRST = 5'h0f;  // Instances 0..2 -> 15..17
   localparam logic [4:0] LINE_GEN_TIMER_FIRST = 5'h12;  // Instances 3..7 -> 18..22
   localparam logic [4:0] LINE_ADC = 5'h17;
   localparam logic [4:0] LINE_ANALOG_COMP = 5'h18;
   localparam logic [4:0] LINE_DAC = 5'h19;
   // Lines 7, 26, 27 reserved; 28..31 absent
   localparam logic [31:0] LINE_USED_MASK = 32'h03ff_ff7f;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [11:0] OFS_LINE_EN_SET = 12'h000;
   localparam logic [11:0] OFS_LINE_EN_CLR = 12'h004;
   localparam logic [11:0] OFS_PEND_SET = 12'h008;
   localparam logic [11:0] OFS_PEND_CLR = 12'h00c;
   localparam logic [11:0] OFS_ACTIVE = 12'h010;
   localparam logic [11:0] OFS_EVT_STATUS = 12'h014;
   localparam logic [11:0] OFS_EVT_CLEAR = 12'h018;
   localparam logic [11:0] OFS_EVT_ENABLE = 12'h01c;
   localparam logic [11:0] OFS_PRIO_BASE = 12'h020;  // Eight words, 0x020..0x03c
   localparam logic [2:0] PER_REGION = 3'h1;  // Peripheral window 0x200..0x3ff
   localparam logic [1:0] PER_FLAG = 2'h0;  // Flag status, write one clears
   localparam logic [1:0] PER_EN_SET = 2'h1;
   localparam logic [1:0] PER_EN_CLR = 2'h2;
   localparam int PRIO_FIELD_POS = 0;  // Field sits in low bits of each byte

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} wr_e;
   typedef enum logic [0:0] {R_IDLE = 1'b0, R_DATA = 1'b1} rd_e;

   // Interrupt signals presented to the processor core
   typedef struct packed {
      logic nmi;
      logic valid;
      logic [4:0] line;
      logic [NUM_PRIO_BITS-1:0] prio;
   } core_irq_s;

   typedef struct packed {
      logic [NUM_LINES-1:0][NUM_FLAGS-1:0] flag;
      logic [NUM_LINES-1:0][NUM_FLAGS-1:0] ien;
      logic [NUM_LINES-1:0] lineEn;
      logic [NUM_LINES-1:0] pend;
      logic [NUM_LINES-1:0][NUM_PRIO_BITS-1:0] prio;
      logic [NUM_LINES-1:0] evtSt;
      logic [NUM_LINES-1:0] evtEn;
      wr_e wSt;
      logic awHave;
      logic [ADDR_W-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp;
      rd_e rSt;
      logic [31:0] rData;
      logic [1:0] rResp;
      core_irq_s core;
   } state_s;

   localparam state_s STATE_RST = '0;

endpackage

// ==== hdl/peripheral_interrupt_routing.sv ====
// Purpose: Peripheral interrupt flags, per-peripheral OR, and a vectored
//          line controller with pending, enable and priority state
// Assumes: Peripheral condition pulses come from logic on clk_sys
// Notes:   Registers reached over AXI4-Lite; one write and one read in flight
//
// Summary of operation
// - Thirty-two request lines, each with a two-bit priority, four levels.
// - Each of the 25 mapped lines is fed by one peripheral only.
// - A peripheral flag sets on its condition regardless of its enable.
// - Writing one to enable-set enables that interrupt; zero has no effect.
// - Writing one to enable-clear disables that interrupt; zero has no effect.
// - A peripheral requests only while some flag and its enable are set.
// - All enabled requests of one peripheral are ORed into one line.
// - A request sets its line pending; software sets and clears pending too.
// - A pending line is activated only if its line enable is set.
// - Priority fields in eight registers order pending lines for activation.
// - External controller non-maskable request goes to the core NMI input.
// - Lines 0..4: power, system control, watchdog, real-time counter, external.
// - Line 5 nonvolatile memory, 6 DMA, 7 reserved, 8 event system.
// - Serial interfaces 0..5 drive lines 9..14 in order.
// - Control timers 0..2 on 15..17, general timers 3..7 on 18..22.
// - Lines 23 ADC, 24 comparator, 25 DAC; 26 and 27 reserved.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module peripheral_interrupt_routing (
   input wire logic clk_sys,
   input wire logic arst_n,
   // Per-line peripheral condition pulses, one byte of flags per line
   input wire logic [31:0][7:0] irqCond,
   input wire logic nmiReq,
   input wire logic actAck,
   output irq_route_pkg::core_irq_s coreIrq,
   output logic irqOut,
   // AXI4-Lite slave
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic [1:0] rstPipe_r;
   logic rstSync;

   // Release is synchronised so no flop leaves reset on a different edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe_r <= 2'b00;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end
   assign rstSync = rstPipe_r[1];

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   irq_route_pkg::state_s s_r;
   irq_route_pkg::state_s s_nxt;
   logic [31:0][7:0] condMasked;
   logic [31:0] lineReq;
   logic [31:0] bestMask;
   logic bestValid;
   logic [4:0] bestLine;
   logic [1:0] bestPrio;
   logic haveA;
   logic haveW;
   logic [11:0] wAddr;
   logic [31:0] wDat;
   logic [3:0] wStb;
   logic [31:0] wMask;
   logic doWrite;
   logic wrEnSet;
   logic wrEnClr;
   logic [4:0] perIdx;
   logic [31:0] rdVal;
   logic rdHit;
   logic [4:0] rdIdx;

   // Reserved and absent lines never carry a condition
   // Byte i of the condition bus is line i, so the map is fixed by wiring
   always_comb begin
      for (int i = 0; i < irq_route_pkg::NUM_LINES; i++) begin
         condMasked[i] = irq_route_pkg::LINE_USED_MASK[i] ? irqCond[i] : 8'h00;
      end
   end

   // One request per peripheral: OR of its enabled flags
   always_comb begin
      for (int i = 0; i < irq_route_pkg::NUM_LINES; i++) begin
         lineReq[i] = |(s_r.flag[i] & s_r.ien[i]);
      end
   end

   // Arbitration: lowest priority value wins, lower line number breaks ties
   // Thirty-two lines, two-bit priority each
   always_comb begin
      bestMask = s_r.pend & s_r.lineEn;
      bestValid = 1'b0;
      bestLine = 5'h00;
      bestPrio = 2'h3;
      for (int i = irq_route_pkg::NUM_LINES - 1; i >= 0; i--) begin
         if (bestMask[i] && (!bestValid || s_r.prio[i] <= bestPrio)) begin
            bestValid = 1'b1;
            bestLine = 5'(i);
            bestPrio = s_r.prio[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite handshakes and write data
   // ------------------------------------------------------------------
   assign awready = !s_r.awHave && (s_r.wSt == irq_route_pkg::W_IDLE);
   assign wready = !s_r.wHave && (s_r.wSt == irq_route_pkg::W_IDLE);
   assign arready = (s_r.rSt == irq_route_pkg::R_IDLE);
   assign bvalid = (s_r.wSt == irq_route_pkg::W_RESP);
   assign bresp = s_r.bResp;
   assign rvalid = (s_r.rSt == irq_route_pkg::R_DATA);
   assign rdata = s_r.rData;
   assign rresp = s_r.rResp;
   assign coreIrq = s_r.core;
   // Level output: any enabled sticky event
   assign irqOut = |(s_r.evtSt & s_r.evtEn);

   // Address and data may arrive in either order; write once both held
   always_comb begin
      haveA = s_r.awHave || (awvalid && awready);
      haveW = s_r.wHave || (wvalid && wready);
      wAddr = s_r.awHave ? s_r.awAddr : awaddr;
      wDat = s_r.wHave ? s_r.wData : wdata;
      wStb = s_r.wHave ? s_r.wStrb : wstrb;
      doWrite = haveA && haveW;
      for (int b = 0; b < 4; b++) begin
         wMask[8*b +: 8] = wStb[b] ? wDat[8*b +: 8] : 8'h00;
      end
      perIdx = wAddr[8:4];
      // Misaligned writes answer SLVERR and change nothing, so they are left out
      wrEnSet = doWrite && (wAddr[11:9] == irq_route_pkg::PER_REGION) && (wAddr[1:0] == 2'h0)
         && irq_route_pkg::LINE_USED_MASK[perIdx] && (wAddr[3:2] == irq_route_pkg::PER_EN_SET);
      wrEnClr = doWrite && (wAddr[11:9] == irq_route_pkg::PER_REGION) && (wAddr[1:0] == 2'h0)
         && irq_route_pkg::LINE_USED_MASK[perIdx] && (wAddr[3:2] == irq_route_pkg::PER_EN_CLR);
   end

   // Read decode; unmapped addresses answer SLVERR with zero data
   always_comb begin
      rdVal = 32'h0000_0000;
      rdHit = 1'b1;
      rdIdx = araddr[8:4];
      if (araddr[11:9] == irq_route_pkg::PER_REGION) begin
         if (!irq_route_pkg::LINE_USED_MASK[rdIdx] || araddr[1:0] != 2'h0) begin
            rdHit = 1'b0;
         end else if (araddr[3:2] == irq_route_pkg::PER_FLAG) begin
            rdVal = {24'h00_0000, s_r.flag[rdIdx]};
         end else if (araddr[3:2] == irq_route_pkg::PER_EN_SET
               || araddr[3:2] == irq_route_pkg::PER_EN_CLR) begin
            rdVal = {24'h00_0000, s_r.ien[rdIdx]};
         end else begin
            rdHit = 1'b0;
         end
      end else if (araddr >= irq_route_pkg::OFS_PRIO_BASE
            && araddr < irq_route_pkg::OFS_PRIO_BASE + 12'h020 && araddr[1:0] == 2'h0) begin
         for (int k = 0; k < 4; k++) begin
            rdVal[8*k + irq_route_pkg::PRIO_FIELD_POS +: 2] =
               s_r.prio[{araddr[4:2], 2'(k)}];
         end
      end else begin
         unique case (araddr)
            irq_route_pkg::OFS_LINE_EN_SET,
            irq_route_pkg::OFS_LINE_EN_CLR: rdVal = s_r.lineEn;
            irq_route_pkg::OFS_PEND_SET,
            irq_route_pkg::OFS_PEND_CLR: rdVal = s_r.pend;
            irq_route_pkg::OFS_ACTIVE: rdVal = {23'h00_0000, s_r.core};
            irq_route_pkg::OFS_EVT_STATUS: rdVal = s_r.evtSt;
            irq_route_pkg::OFS_EVT_CLEAR: rdVal = 32'h0000_0000;
            irq_route_pkg::OFS_EVT_ENABLE: rdVal = s_r.evtEn;
            default: rdHit = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] pendSet;
      logic [31:0] pendClr;
      logic [31:0] enSet;
      logic [31:0] enClr;
      logic [31:0] evtClr;
      logic [31:0] ackMask;
      logic [31:0][7:0] flagClr;
      logic [31:0][7:0] ienSet;
      logic [31:0][7:0] ienClr;
      logic wrHit;
      s_nxt = s_r;
      pendSet = 32'h0000_0000;
      pendClr = 32'h0000_0000;
      enSet = 32'h0000_0000;
      enClr = 32'h0000_0000;
      evtClr = 32'h0000_0000;
      ackMask = 32'h0000_0000;
      flagClr = '0;
      ienSet = '0;
      ienClr = '0;
      wrHit = 1'b1;

      // Channel capture
      if (awvalid && awready) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wData = wdata;
         s_nxt.wStrb = wstrb;
      end

      // Register writes; only bytes with a strobe take effect, except event enable, where unstrobed bytes load zero
      if (doWrite) begin
         if (wAddr[11:9] == irq_route_pkg::PER_REGION) begin
            if (!irq_route_pkg::LINE_USED_MASK[perIdx] || wAddr[1:0] != 2'h0) begin
               wrHit = 1'b0;
            end else if (wAddr[3:2] == irq_route_pkg::PER_FLAG) begin
               flagClr[perIdx] = wMask[7:0];
            end else if (wAddr[3:2] == irq_route_pkg::PER_EN_SET) begin
               ienSet[perIdx] = wMask[7:0];
            end else if (wAddr[3:2] == irq_route_pkg::PER_EN_CLR) begin
               ienClr[perIdx] = wMask[7:0];
            end else begin
               wrHit = 1'b0;
            end
         end else if (wAddr >= irq_route_pkg::OFS_PRIO_BASE
               && wAddr < irq_route_pkg::OFS_PRIO_BASE + 12'h020 && wAddr[1:0] == 2'h0) begin
            for (int k = 0; k < 4; k++) begin
               if (wStb[k]) begin
                  s_nxt.prio[{wAddr[4:2], 2'(k)}] =
                     wDat[8*k + irq_route_pkg::PRIO_FIELD_POS +: 2];
               end
            end
         end else begin
            unique case (wAddr)
               irq_route_pkg::OFS_LINE_EN_SET: enSet = wMask;
               irq_route_pkg::OFS_LINE_EN_CLR: enClr = wMask;
               irq_route_pkg::OFS_PEND_SET: pendSet = wMask;
               irq_route_pkg::OFS_PEND_CLR: pendClr = wMask;
               irq_route_pkg::OFS_EVT_CLEAR: evtClr = wMask;
               irq_route_pkg::OFS_EVT_ENABLE: s_nxt.evtEn = wMask;
               irq_route_pkg::OFS_ACTIVE,
               irq_route_pkg::OFS_EVT_STATUS: wrHit = 1'b1;
               default: wrHit = 1'b0;
            endcase
         end
      end

      // Peripheral flags: a condition wins over a same-cycle clear
      for (int i = 0; i < irq_route_pkg::NUM_LINES; i++) begin
         s_nxt.flag[i] = (s_r.flag[i] & ~flagClr[i]) | condMasked[i];
         s_nxt.ien[i] = ((s_r.ien[i] & ~ienClr[i]) | ienSet[i])
            & {8{irq_route_pkg::LINE_USED_MASK[i]}};
      end

      // Acknowledge by the core retires the presented line
      if (actAck && s_r.core.valid) begin
         ackMask[s_r.core.line] = 1'b1;
      end

      // Pending: hardware request and software set win over clears
      s_nxt.pend = ((s_r.pend & ~pendClr & ~ackMask) | pendSet | lineReq)
         & irq_route_pkg::LINE_USED_MASK;
      s_nxt.lineEn = ((s_r.lineEn & ~enClr) | enSet) & irq_route_pkg::LINE_USED_MASK;
      // Sticky event: a line newly made pending by its peripheral
      s_nxt.evtSt = (s_r.evtSt & ~evtClr) | (lineReq & ~s_r.pend);

      // Presented interrupt is registered so the core sees stable data
      s_nxt.core.valid = bestValid;
      s_nxt.core.line = bestLine;
      s_nxt.core.prio = bestPrio;
      s_nxt.core.nmi = nmiReq;

      // Write channel sequencing
      unique case (s_r.wSt)
         irq_route_pkg::W_IDLE: begin
            if (doWrite) begin
               s_nxt.awHave = 1'b0;
               s_nxt.wHave = 1'b0;
               s_nxt.bResp = wrHit ? irq_route_pkg::RESP_OKAY : irq_route_pkg::RESP_SLVERR;
               s_nxt.wSt = irq_route_pkg::W_RESP;
            end
         end
         irq_route_pkg::W_RESP: begin
            if (bready) begin
               s_nxt.wSt = irq_route_pkg::W_IDLE;
            end
         end
      endcase

      // Read channel sequencing
      unique case (s_r.rSt)
         irq_route_pkg::R_IDLE: begin
            if (arvalid) begin
               s_nxt.rData = rdHit ? rdVal : 32'h0000_0000;
               s_nxt.rResp = rdHit ? irq_route_pkg::RESP_OKAY : irq_route_pkg::RESP_SLVERR;
               s_nxt.rSt = irq_route_pkg::R_DATA;
            end
         end
         irq_route_pkg::R_DATA: begin
            if (rready) begin
               s_nxt.rSt = irq_route_pkg::R_IDLE;
            end
         end
      endcase
   end

   // Single register stage for the whole block
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         s_r <= irq_route_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstSync);

   AST_FLAG_SETS: assert property (
      (condMasked != '0) |=> ((s_r.flag & $past(condMasked)) == $past(condMasked)))
      else $error("Flag did not set on its condition");

   AST_EN_SET: assert property (
      wrEnSet |=> ((s_r.ien[$past(perIdx)] & $past(wMask[7:0])) == $past(wMask[7:0])))
      else $error("Enable set write did not enable");

   AST_EN_CLR: assert property (
      (wrEnClr && !wrEnSet) |=> ((s_r.ien[$past(perIdx)] & $past(wMask[7:0])) == 8'h00))
      else $error("Enable clear write did not disable");

   AST_REQ_PENDS: assert property (
      (lineReq != '0) |=> ((s_r.pend & $past(lineReq)) == $past(lineReq)))
      else $error("Request did not set pending");

   AST_NO_ACT_DISABLED: assert property (
      ((s_r.pend & s_r.lineEn) == '0) |=> !s_r.core.valid)
      else $error("Line activated without pending and enable");

   AST_PRIO_USED: assert property (
      bestValid |=> (s_r.core.valid && (s_r.core.line == $past(bestLine))
         && (s_r.core.prio == $past(s_r.prio[bestLine]))))
      else $error("Presented priority does not match line field");

   AST_NMI_ROUTE: assert property (
      nmiReq |=> coreIrq.nmi)
      else $error("Non-maskable request not routed");

   AST_RSVD_TIED: assert property (
      ((s_r.pend | s_r.lineEn) & ~irq_route_pkg::LINE_USED_MASK) == '0)
      else $error("Reserved line became pending or enabled");

endmodule // peripheral_interrupt_routing

// ==== bench/irq_source_model.sv ====
// Purpose: Far-side model: peripheral condition pulses and the core acknowledge
// Assumes: Commands arrive from the bench one cycle ahead of the effect
// Notes:   Conditions are single pulses so only the flag storage can hold them
`timescale 1ns/1ps

module irq_source_model (
   input wire logic clk_sys,
   input wire logic fire,
   input wire logic [4:0] fireLine,
   input wire logic [2:0] fireBit,
   input wire logic ackGo,
   input irq_route_pkg::core_irq_s coreIrq,
   output logic [31:0][7:0] irqCond,
   output logic actAck
);
   initial begin
      irqCond = '0;
      actAck = 1'b0;
   end

   // One pulse per command; ack only what the core really presents
   always @(posedge clk_sys) begin
      irqCond <= '0;
      if (fire) begin
         irqCond[fireLine][fireBit] <= 1'b1;
      end
      actAck <= ackGo && coreIrq.valid;
   end
endmodule // irq_source_model

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the peripheral interrupt routing block
// Assumes: AXI4-Lite master tasks, ready sampled on the falling edge before each rising edge
// Notes:   Random flag bits and priorities from a fixed seed
`timescale 1ns/1ps

module tb_top;
   logic clk_sys = 1'b0, arst_n = 1'b0, nmiReq = 1'b0, fire = 1'b0, ackGo = 1'b0;
   logic [4:0] fireLine = 5'h00;
   logic [2:0] fireBit = 3'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, irqOut, actAck;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d, m, bm;
   logic [31:0][7:0] irqCond;
   irq_route_pkg::core_irq_s coreIrq;
   int miscompares = 0, samples_checked = 0, seed, cycles = 0, b, pa, pb, w;
   logic [11:0] p;

   peripheral_interrupt_routing peripheral_interrupt_routing_inst (.clk_sys(clk_sys),
      .arst_n(arst_n), .irqCond(irqCond), .nmiReq(nmiReq), .actAck(actAck),
      .coreIrq(coreIrq), .irqOut(irqOut), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   irq_source_model irq_source_model_inst (.clk_sys(clk_sys), .fire(fire),
      .fireLine(fireLine), .fireBit(fireBit), .ackGo(ackGo), .coreIrq(coreIrq),
      .irqCond(irqCond), .actAck(actAck));

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   // Lines that a peripheral drives: 0..25 except the reserved 7
   function automatic logic [31:0] used_mask();
      logic [31:0] u;
      u = '0;
      for (int i = 0; i < 26; i++) u[i] = (i != 7);
      return u;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ready is combinational from state, so its negedge value holds at the next edge
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (tb !== 1'b1);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid;
         v = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
      end while (tr !== 1'b1);
   endtask

   task automatic pulse(input int ln, input int bit_n);
      fireLine <= ln[4:0];
      fireBit <= bit_n[2:0];
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic close_out();
      $display("comparisons=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under two thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      seed = 21924;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(irq_route_pkg::OFS_LINE_EN_SET, d);
      chk(d, 32'h0000_0000);
      rd(12'h100, d);
      chk({30'h0, r}, {30'h0, irq_route_pkg::RESP_SLVERR});
      $display("test reset and unmapped done");
      // Every line: flag, enable set/clear, request, pending
      for (int i = 0; i < 32; i++) begin
         b = $unsigned($random(seed)) % 8;
         m = used_mask();
         bm = m[i] ? (32'h1 << b) : 32'h0;
         p = 12'h200 + 12'(i * 16);
         pulse(i, b);
         rd(p, d);
         chk(d, bm);
         rd(irq_route_pkg::OFS_PEND_SET, d);
         chk(d, 32'h0);
         wr(p + 12'h004, 32'h1 << b);
         chk({30'h0, r}, {30'h0, m[i] ? irq_route_pkg::RESP_OKAY : irq_route_pkg::RESP_SLVERR});
         wr(p + 12'h004, 32'h0);
         rd(p + 12'h004, d);
         chk(d, bm);
         rd(irq_route_pkg::OFS_PEND_SET, d);
         chk(d, m[i] ? (32'h1 << i) : 32'h0);
         chk({31'h0, coreIrq.valid}, 32'h0);
         wr(p + 12'h008, 32'h0);
         rd(p + 12'h004, d);
         chk(d, bm);
         wr(p + 12'h008, 32'h1 << b);
         rd(p + 12'h004, d);
         chk(d, 32'h0);
         wr(p, 32'hff);
         wr(irq_route_pkg::OFS_PEND_CLR, 32'h1 << i);
         rd(irq_route_pkg::OFS_PEND_SET, d);
         chk(d, 32'h0);
      end
      $display("test line map done");
      // Event status interrupt: masked, raised, cleared
      chk({31'h0, irqOut}, 32'h0);
      rd(irq_route_pkg::OFS_EVT_STATUS, d);
      chk(d, used_mask());
      wr(irq_route_pkg::OFS_EVT_ENABLE, 32'hffff_ffff);
      chk({31'h0, irqOut}, 32'h1);
      wr(irq_route_pkg::OFS_EVT_CLEAR, 32'hffff_ffff);
      chk({31'h0, irqOut}, 32'h0);
      $display("test event interrupt done");
      // Priority order between lines 12 and 20, then acknowledge the winner
      wr(irq_route_pkg::OFS_LINE_EN_SET, 32'h0010_1000);
      for (int k = 0; k < 6; k++) begin
         pa = $unsigned($random(seed)) % 4;
         pb = $unsigned($random(seed)) % 4;
         wr(12'h02c, 32'(pa));
         wr(12'h034, 32'(pb));
         wr(irq_route_pkg::OFS_PEND_SET, 32'h0010_1000);
         repeat (3) @(posedge clk_sys);
         w = (pb < pa) ? 20 : 12;
         chk({27'h0, coreIrq.line}, 32'(w));
         chk({30'h0, coreIrq.prio}, 32'((pb < pa) ? pb : pa));
         ackGo <= 1'b1;
         @(posedge clk_sys);
         ackGo <= 1'b0;
         repeat (4) @(posedge clk_sys);
         chk({27'h0, coreIrq.line}, 32'((w == 20) ? 12 : 20));
         wr(irq_route_pkg::OFS_PEND_CLR, 32'hffff_ffff);
      end
      // Line enable clear: pending lines must no longer be presented
      wr(irq_route_pkg::OFS_LINE_EN_CLR, 32'h0010_1000);
      wr(irq_route_pkg::OFS_PEND_SET, 32'h0010_1000);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, coreIrq.valid}, 32'h0);
      rd(irq_route_pkg::OFS_LINE_EN_SET, d);
      chk(d, 32'h0);
      $display("test priority done");
      nmiReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({30'h0, coreIrq.nmi, coreIrq.valid}, 32'h2);
      nmiReq <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, coreIrq.nmi}, 32'h0);
      $display("test nmi done");
      close_out();
   end
endmodule // tb_top
